// ===== rtl/watchdog_map.svh
// watchdog constants: offsets, field positions, reset values, counts
// assumes inclusion by the watchdog package and modules only
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// ============================================================
// bus layout
`define WDT_AXI_ADDR_W       8
`define WDT_CSR_OFFSET       8'h00
`define WDT_RESP_OKAY        2'h0
`define WDT_RESP_SLVERR      2'h2

// ============================================================
// control and status field positions
`define WDT_FLAG_BIT         7
`define WDT_IRQ_EN_BIT       6
`define WDT_PS3_BIT          5
`define WDT_CE_BIT           4
`define WDT_SRE_BIT          3
`define WDT_PS_LO_MSB        2
`define WDT_CSR_RESET        8'h00

// ============================================================
// timing
`define WDT_OSC_KHZ          128
`define WDT_CE_WINDOW_CYCLES 3'h4
`define WDT_CNT_W            21
`define WDT_BASE_TIMEOUT     21'h000800
`define WDT_PS_MAX_CODE      4'h9

`endif

// ===== rtl/watchdog_pkg.sv
// watchdog state types
// assumes watchdog_map.svh is on the include path
`include "watchdog_map.svh"

package watchdog_pkg;

	typedef logic [`WDT_CNT_W-1:0] count_t;

	typedef struct packed {
		logic                       flag;
		logic                       irq_en;
		logic                       sys_rst_en;
		logic [3:0]                 prescale;
		logic                       irq;
		logic                       rst;
		logic                       awready;
		logic                       wready;
		logic                       aw_got;
		logic                       w_got;
		logic [`WDT_AXI_ADDR_W-1:0] aw_addr;
		logic [7:0]                 wbyte;
		logic                       wlane;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
	} csr_state_s;

	typedef struct packed {
		count_t count;
		logic   expire;
	} cnt_state_s;

	typedef struct packed {
		logic       open;
		logic [2:0] left;
	} ce_state_s;

endpackage : watchdog_pkg

// ===== rtl/watchdog_counter.sv
// oscillator tick counter with prescaled time-out compare
// assumes osc_tick is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
`include "watchdog_map.svh"

module watchdog_counter
	import watchdog_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       osc_tick,
	input  wire logic       restart,
	input  wire logic       run,
	input  wire logic [3:0] prescale,
	output logic            expire
);

	cnt_state_s st_r;
	cnt_state_s st_nxt;

	// ============================================================
	// time-out limit per prescale code
	function automatic count_t timeout_limit(input logic [3:0] code);
		logic [3:0] c;
		c = (code > `WDT_PS_MAX_CODE) ? `WDT_PS_MAX_CODE : code;
		timeout_limit = count_t'(`WDT_BASE_TIMEOUT << c);
	endfunction : timeout_limit

	// ============================================================
	// counting
	always_comb begin
		st_nxt        = st_r;
		st_nxt.expire = 1'b0;
		if (restart || !run) begin
			st_nxt.count = '0;
		end else if (osc_tick) begin
			if (st_r.count + count_t'(1) >= timeout_limit(prescale)) begin
				st_nxt.count  = '0;
				st_nxt.expire = 1'b1;
			end else begin
				st_nxt.count = st_r.count + count_t'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expire = st_r.expire;

endmodule : watchdog_counter

// ===== rtl/watchdog_change_window.sv
// timed change-enable window
// assumes arm and disarm are one-cycle register write strobes
`timescale 1ns/1ps
`include "watchdog_map.svh"

module watchdog_change_window
	import watchdog_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic arm,
	input  wire logic disarm,
	output logic      open
);

	ce_state_s st_r;
	ce_state_s st_nxt;

	// ============================================================
	// window timing
	always_comb begin
		st_nxt = st_r;
		if (arm) begin
			st_nxt.open = 1'b1;
			st_nxt.left = `WDT_CE_WINDOW_CYCLES;
		end else if (disarm) begin
			st_nxt.open = 1'b0;
			st_nxt.left = 3'h0;
		end else if (st_r.left != 3'h0) begin
			st_nxt.left = st_r.left - 3'h1;
			if (st_r.left == 3'h1) begin
				st_nxt.open = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign open = st_r.open;

endmodule : watchdog_change_window

// ===== rtl/watchdog_timer_control.sv
// watchdog control and status register, mode logic and bus slave
// assumes an AXI4-Lite master on clk and a synchronous oscillator tick
`timescale 1ns/1ps
`include "watchdog_map.svh"

module watchdog_timer_control
	import watchdog_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic [`WDT_AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [`WDT_AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       osc_tick,
	input  wire logic                       wdr_exec,
	input  wire logic                       irq_vector_ack,
	input  wire logic                       global_irq_enable,
	input  wire logic                       always_on_fuse,
	input  wire logic                       reset_cause_flag,
	output logic                            timeout_irq,
	output logic                            sys_reset_pulse
);

	csr_state_s st_r;
	csr_state_s st_nxt;
	logic       expire;
	logic       ce_open;
	logic       csr_wr;
	logic       ce_arm;
	logic       ce_disarm;
	logic       run;
	logic [7:0] wb;

	// ============================================================
	// register byte image
	function automatic logic [7:0] csr_image(input csr_state_s s, input logic ce);
		logic [7:0] v;
		v                    = `WDT_CSR_RESET;
		v[`WDT_FLAG_BIT]     = s.flag;
		v[`WDT_IRQ_EN_BIT]   = s.irq_en;
		v[`WDT_PS3_BIT]      = s.prescale[3];
		v[`WDT_CE_BIT]       = ce;
		v[`WDT_SRE_BIT]      = s.sys_rst_en;
		v[`WDT_PS_LO_MSB:0]  = s.prescale[2:0];
		csr_image            = v;
	endfunction : csr_image

	function automatic logic addr_hit(input logic [`WDT_AXI_ADDR_W-1:0] a);
		addr_hit = (a[`WDT_AXI_ADDR_W-1:2] == (`WDT_AXI_ADDR_W-2)'(`WDT_CSR_OFFSET >> 2));
	endfunction : addr_hit

	// ============================================================
	// helpers
	assign wb        = st_r.wbyte;
	assign csr_wr    = st_r.aw_got && st_r.w_got && !st_r.bvalid && addr_hit(st_r.aw_addr) && st_r.wlane;
	assign ce_arm    = csr_wr && wb[`WDT_CE_BIT];
	assign ce_disarm = csr_wr && !wb[`WDT_CE_BIT];
	assign run       = st_r.sys_rst_en || st_r.irq_en;

	// ============================================================
	// next state
	always_comb begin
		st_nxt     = st_r;
		st_nxt.rst = 1'b0;

		// write address and data channels, either order
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_got  = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wbyte = s_axi_wdata[7:0];
			st_nxt.wlane = s_axi_wstrb[0];
		end

		// vector execution
		if (irq_vector_ack) begin
			st_nxt.flag = 1'b0;
			// combined falls back to reset mode
			if (st_r.sys_rst_en) begin
				st_nxt.irq_en = 1'b0;
			end
		end

		// register write
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = addr_hit(st_r.aw_addr) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
			if (csr_wr) begin
				if (wb[`WDT_FLAG_BIT]) begin
					st_nxt.flag = 1'b0;
				end
				st_nxt.irq_en = wb[`WDT_IRQ_EN_BIT];
				if (wb[`WDT_SRE_BIT]) begin
					st_nxt.sys_rst_en = 1'b1;
				end else if (ce_open) begin
					st_nxt.sys_rst_en = 1'b0;
				end
				if (ce_open) begin
					st_nxt.prescale = {wb[`WDT_PS3_BIT], wb[`WDT_PS_LO_MSB:0]};
				end
			end
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// read channel
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			if (addr_hit(s_axi_araddr)) begin
				st_nxt.rdata = {24'h000000, csr_image(st_r, ce_open)};
				st_nxt.rresp = `WDT_RESP_OKAY;
			end else begin
				st_nxt.rdata = 32'h00000000;
				st_nxt.rresp = `WDT_RESP_SLVERR;
			end
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end

		// expiry actions, set wins over clear
		if (expire) begin
			if (st_r.sys_rst_en && (!st_r.irq_en || st_r.flag)) begin
				st_nxt.rst = 1'b1;
			end
			if (st_r.irq_en && !(st_r.sys_rst_en && st_r.flag)) begin
				st_nxt.flag = 1'b1;
			end
		end

		if (reset_cause_flag) begin
			st_nxt.sys_rst_en = 1'b1;
		end
		if (always_on_fuse) begin
			st_nxt.sys_rst_en = 1'b1;
			st_nxt.irq_en     = 1'b0;
		end

		st_nxt.irq = global_irq_enable && st_nxt.irq_en && st_nxt.flag;

		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;
	end

	// ============================================================
	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ============================================================
	// sub blocks
	// restart on instruction or reset
	watchdog_counter u_counter (
		.clk      (clk),
		.srst     (srst),
		.osc_tick (osc_tick),
		.restart  (wdr_exec),
		.run      (run),
		.prescale (st_r.prescale),
		.expire   (expire)
	);

	watchdog_change_window u_window (
		.clk    (clk),
		.srst   (srst),
		.arm    (ce_arm),
		.disarm (ce_disarm),
		.open   (ce_open)
	);

	// ============================================================
	// outputs
	assign s_axi_awready   = st_r.awready;
	assign s_axi_wready    = st_r.wready;
	assign s_axi_bresp     = st_r.bresp;
	assign s_axi_bvalid    = st_r.bvalid;
	assign s_axi_arready   = st_r.arready;
	assign s_axi_rdata     = st_r.rdata;
	assign s_axi_rresp     = st_r.rresp;
	assign s_axi_rvalid    = st_r.rvalid;
	assign timeout_irq     = st_r.irq;
	assign sys_reset_pulse = st_r.rst;

endmodule : watchdog_timer_control

// ===== dv/watchdog_timer_control_monitor.sv
// watchdog control checker and its bind
// assumes the port names of watchdog_timer_control
`timescale 1ns/1ps
`include "watchdog_map.svh"
// ============================================================
// checker
module watchdog_timer_control_monitor (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        global_irq_enable,
	input wire logic        always_on_fuse,
	input wire logic        reset_cause_flag,
	input wire logic        timeout_irq,
	input wire logic        sys_reset_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	irq_gated_a: assert property (timeout_irq |-> $past(global_irq_enable))
		else $error("irq without global enable");
	fuse_irq_a: assert property (always_on_fuse [*3] |-> !timeout_irq)
		else $error("irq under fuse");
	pulse_once_a: assert property (sys_reset_pulse |=> !sys_reset_pulse)
		else $error("reset pulse too long");
	cause_sre_a: assert property (s_axi_arvalid && s_axi_arready && $past(reset_cause_flag) && !$past(srst)
		|=> s_axi_rdata[3]) else $error("reset enable not held");
	fuse_read_a: assert property (s_axi_arvalid && s_axi_arready && $past(always_on_fuse) && !$past(srst)
		|=> s_axi_rdata[3] && !s_axi_rdata[6]) else $error("fuse not forcing");
	b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	r_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h03
		|=> s_axi_rresp == `WDT_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
	cover property ($rose(timeout_irq));
	cover property (sys_reset_pulse);
	cover property (s_axi_bvalid && s_axi_bresp == `WDT_RESP_SLVERR);
endmodule : watchdog_timer_control_monitor

bind watchdog_timer_control watchdog_timer_control_monitor watchdog_timer_control_monitor_inst (.*);

// ===== dv/watchdog_timer_control_bench.sv
// watchdog control bench: bus, expiry and protection scenarios
// assumes osc_tick held high gives one tick per clock
`timescale 1ns/1ps
`include "watchdog_map.svh"
// ============================================================
// bench
module watchdog_timer_control_bench;
	localparam logic [1:0] OK = `WDT_RESP_OKAY;
	localparam logic [1:0] ER = `WDT_RESP_SLVERR;
	localparam logic [7:0] A  = `WDT_CSR_OFFSET;
	localparam int         T  = `WDT_BASE_TIMEOUT;
	logic        clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        osc_tick, wdr_exec, irq_vector_ack, global_irq_enable, always_on_fuse, reset_cause_flag;
	logic        timeout_irq, sys_reset_pulse;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	int          mismatches, n_tests;

	watchdog_timer_control watchdog_timer_control_inst (.*);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task automatic print_verdict;
		$display("mismatches %0d tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic lost(input string nm);
		mismatches++;
		$display("CHECK FAILED %s expected done seen timeout", nm);
		print_verdict();
	endtask : lost

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		logic ha, hw, hb;
		int   i;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(negedge clk);
			ha = s_axi_awvalid & s_axi_awready;
			hw = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bvalid;
			if (hb) chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
			@(posedge clk);
			if (ha) s_axi_awvalid <= 1'h0;
			if (hw) s_axi_wvalid <= 1'h0;
			if (hb) break;
		end
		if (i == 20) lost("write");
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		logic ha, hr;
		int   i;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(negedge clk);
			ha = s_axi_arvalid & s_axi_arready;
			hr = s_axi_rvalid;
			if (hr) chk("rdata", {24'h0, e}, s_axi_rdata);
			if (hr) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
			@(posedge clk);
			if (ha) s_axi_arvalid <= 1'h0;
			if (hr) break;
		end
		if (i == 20) lost("read");
	endtask : rd

	// s high waits for the reset pulse, low for the interrupt
	task automatic wt(input logic s, input int n_exp);
		int n;
		for (n = 1; n <= n_exp + 4; n++) begin
			@(negedge clk);
			if (s ? sys_reset_pulse : timeout_irq) break;
		end
		if (n > n_exp + 4) lost("expiry");
		chk("expiry early", 32'h1, {31'h0, n >= n_exp - 8});
		@(posedge clk);
	endtask : wt

	task automatic restart;
		wdr_exec <= 1'h1;
		@(posedge clk);
		wdr_exec <= 1'h0;
	endtask : restart

	task automatic t_bus;
		rd(A, 8'h00, OK);
		wr(8'h10, 8'h48, ER);
		rd(8'h10, 8'h00, ER);
		s_axi_wstrb <= 4'hE;
		wr(A, 8'h48, OK);
		s_axi_wstrb <= 4'hF;
		rd(A, 8'h00, OK);
	endtask : t_bus

	task automatic t_irq;
		wr(A, 8'h40, OK);
		repeat (1000) @(posedge clk);
		restart();
		wt(1'h0, T);
		rd(A, 8'hC0, OK);
		global_irq_enable <= 1'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("irq masked", 32'h0, {31'h0, timeout_irq});
		@(posedge clk);
		global_irq_enable <= 1'h1;
		wr(A, 8'h40, OK);
		rd(A, 8'hC0, OK);
		wr(A, 8'hC0, OK);
		rd(A, 8'h40, OK);
		wr(A, 8'h00, OK);
	endtask : t_irq

	task automatic t_combined;
		wr(A, 8'h48, OK);
		wt(1'h0, T);
		irq_vector_ack <= 1'h1;
		@(posedge clk);
		irq_vector_ack <= 1'h0;
		rd(A, 8'h08, OK);
		wr(A, 8'h48, OK);
		restart();
		wt(1'h0, T);
		wt(1'h1, T);
		wr(A, 8'h88, OK);
	endtask : t_combined

	task automatic t_window;
		restart();
		wr(A, 8'h18, OK);
		wr(A, 8'h09, OK);
		rd(A, 8'h09, OK);
		restart();
		wt(1'h1, 2 * T);
		wr(A, 8'h18, OK);
		repeat (6) @(posedge clk);
		wr(A, 8'h00, OK);
		rd(A, 8'h09, OK);
		wr(A, 8'h18, OK);
		wr(A, 8'h00, OK);
		rd(A, 8'h00, OK);
	endtask : t_window

	task automatic t_force;
		always_on_fuse <= 1'h1;
		repeat (2) @(posedge clk);
		wr(A, 8'h40, OK);
		rd(A, 8'h08, OK);
		always_on_fuse <= 1'h0;
		reset_cause_flag <= 1'h1;
		srst <= 1'h1;
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		rd(A, 8'h08, OK);
		wr(A, 8'h18, OK);
		wr(A, 8'h00, OK);
		rd(A, 8'h08, OK);
		reset_cause_flag <= 1'h0;
		@(posedge clk);
		wr(A, 8'h18, OK);
		wr(A, 8'h00, OK);
		rd(A, 8'h00, OK);
	endtask : t_force

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{osc_tick, wdr_exec, irq_vector_ack, global_irq_enable, always_on_fuse, reset_cause_flag} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		srst = 1'h1;
		mismatches = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		osc_tick <= 1'h1;
		global_irq_enable <= 1'h1;
		@(posedge clk);
		t_bus();
		t_irq();
		t_combined();
		t_window();
		t_force();
		print_verdict();
	end
endmodule : watchdog_timer_control_bench
